// ### hdl/cvm_defs.vh
/*
 * Shared constants of the constant-speed move unit: task state codes,
 * direction codes, fault words and speed tolerances.
 * Assumes speeds are signed 32-bit integers in axis speed units.
 */
`ifndef CVM_DEFS_VH
`define CVM_DEFS_VH

// Width of speed values and of the direction selector
`define CVM_SPEED_W        32
`define CVM_DIR_W          16
`define CVM_CODE_W         16

// Direction selector codes
`define CVM_DIR_SIGN       16'h0000
`define CVM_DIR_POS        16'h0001
`define CVM_DIR_NEG        16'h0002

// Speed a caller should use when it has no better value
`define CVM_SPEED_DEFAULT  32'h0000000A
`define CVM_SPEED_ZERO     32'h00000000

// Band around a target counted as reached, and around zero as standstill
`define CVM_SPEED_TOL      32'h00000000
`define CVM_STILL_TOL      32'h00000000

// Fault code words, zero while no fault stands
`define CVM_FAULT_NONE     16'h0000
`define CVM_FAULT_DISABLED 16'h0001
`define CVM_FAULT_DIR      16'h0002
`define CVM_FAULT_SPEED    16'h0003

// Fault detail words
`define CVM_DETAIL_NONE    16'h0000
`define CVM_DETAIL_AXIS    16'h0001
`define CVM_DETAIL_PARAM   16'h0002

// One-hot task states
`define CVM_ST_W           7
`define CVM_ST_IDLE        7'h01
`define CVM_ST_RAMP        7'h02
`define CVM_ST_HOLD        7'h04
`define CVM_ST_STOP        7'h08
`define CVM_ST_DONE        7'h10
`define CVM_ST_SUPER       7'h20
`define CVM_ST_FAULT       7'h40

`endif

// ### hdl/cvm_edge.v
/*
 * Rising-edge detector for the start request.
 * Assumes the request is synchronous to clk_sys and idles low.
 */
`timescale 1ns/1ps
`default_nettype none

module cvm_edge (
  input  wire clk_sys,
  input  wire rst_n,
  input  wire level,
  output wire rise
);

  reg prev;

  // Previous level starts low so a request held through reset still counts
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;

endmodule // cvm_edge

`default_nettype wire

// ### hdl/cvm_check.v
/*
 * Parameter check and signed target for a constant-speed task.
 * Assumes limits are positive magnitudes and start_stop <= maximum.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cvm_defs.vh"

module cvm_check (
  input  wire signed [`CVM_SPEED_W-1:0] speed_cmd,
  input  wire        [`CVM_DIR_W-1:0]   direction,
  input  wire        [`CVM_SPEED_W-1:0] start_stop_speed,
  input  wire        [`CVM_SPEED_W-1:0] max_speed,
  output reg  signed [`CVM_SPEED_W-1:0] target,
  output reg                            zero_speed,
  output reg                            bad_dir,
  output reg                            bad_speed
);

  reg [`CVM_SPEED_W-1:0] mag;

  // Magnitude, range test and direction decode
  always @* begin
    mag = speed_cmd[`CVM_SPEED_W-1] ? (~speed_cmd + 32'h00000001)
                                    : speed_cmd;
    zero_speed = (speed_cmd == `CVM_SPEED_ZERO);
    bad_speed  = ~zero_speed &&
                 ((mag < start_stop_speed) || (mag > max_speed));
    bad_dir    = 1'b0;
    case (direction)
      `CVM_DIR_SIGN: target = speed_cmd;
      `CVM_DIR_POS:  target = mag;
      `CVM_DIR_NEG:  target = ~mag + 32'h00000001;
      default: begin
        target  = `CVM_SPEED_ZERO;
        bad_dir = 1'b1;
      end
    endcase
  end

endmodule // cvm_check

`default_nettype wire

// ### hdl/cvm_move_velocity.v
/*
 * Constant-speed move unit for one motion axis. Takes a task on a
 * rising start edge, hands a target speed to the drive, reports
 * at-speed, busy, superseded and fault state, and keeps the axis
 * status bits for speed mode and steady motion.
 * Assumes one clk_sys cycle is one program scan, that the drive ramps
 * to target_speed with its own configured acceleration and
 * deceleration, and that the axis reports its actual speed each cycle.
 */
// Overview of operation
// - Accept task only on rising start edge
// - Direction code: sign, forced positive, forced negative
// - Hold off: use supplied speed and direction
// - Hold on: keep speed present at start
// - Hold on: at-speed once moving at kept speed
// - Hold off: at-speed when commanded speed reached
// - Busy true while task executes
// - Superseded flag when another task cancels this
// - Error with fault code and detail words
// - Other motion task starts cancel running task
// - Starting this task cancels other active tasks
// - Replacing task ramps to new target, at-speed
// - At target, keep moving until superseded
// - Zero speed acts as a stop task
// - Zero speed: at-speed at standstill, one scan
// - Zero speed: busy falls with at-speed
// - Held start request latches at-speed; busy stays low
// - Task start sets speed-mode status bit
// - Standstill under zero-speed task sets steady-motion bit
// - Any new task except a refused one updates both status bits
`timescale 1ns/1ps
`default_nettype none
`include "cvm_defs.vh"

module cvm_move_velocity (
  input  wire                           clk_sys,
  input  wire                           resetn,
  input  wire                           execute,
  input  wire signed [`CVM_SPEED_W-1:0] speed_cmd,
  input  wire        [`CVM_DIR_W-1:0]   direction,
  input  wire                           hold_speed,
  input  wire                           axis_enabled,
  input  wire signed [`CVM_SPEED_W-1:0] axis_speed,
  input  wire        [`CVM_SPEED_W-1:0] start_stop_speed,
  input  wire        [`CVM_SPEED_W-1:0] max_speed,
  input  wire                           other_task_start,
  output reg                            at_speed,
  output reg                            busy,
  output reg                            superseded_flag,
  output reg                            error,
  output reg         [`CVM_CODE_W-1:0]  fault_code,
  output reg         [`CVM_CODE_W-1:0]  fault_detail,
  output reg  signed [`CVM_SPEED_W-1:0] target_speed,
  output reg                            move_request,
  output reg                            cancel_others,
  output reg                            speed_mode_status,
  output reg                            steady_motion_status
);

  // Reset synchroniser: first stage feeds only the second
  reg rst_meta;
  reg rst_n;

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  wire                           start_rise;
  wire signed [`CVM_SPEED_W-1:0] chk_target;
  wire                           chk_zero;
  wire                           chk_bad_dir;
  wire                           chk_bad_speed;

  cvm_edge u_edge (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .level   (execute),
    .rise    (start_rise)
  );

  cvm_check u_check (
    .speed_cmd        (speed_cmd),
    .direction        (direction),
    .start_stop_speed (start_stop_speed),
    .max_speed        (max_speed),
    .target           (chk_target),
    .zero_speed       (chk_zero),
    .bad_dir          (chk_bad_dir),
    .bad_speed        (chk_bad_speed)
  );

  // Distance of actual speed from target and from zero
  wire signed [`CVM_SPEED_W-1:0] diff;
  wire        [`CVM_SPEED_W-1:0] diff_mag;
  wire        [`CVM_SPEED_W-1:0] speed_mag;
  wire                           reached;
  wire                           standstill;

  assign diff      = axis_speed - target_speed;
  assign diff_mag  = diff[`CVM_SPEED_W-1] ? (~diff + 32'h00000001) : diff;
  assign speed_mag = axis_speed[`CVM_SPEED_W-1]
                     ? (~axis_speed + 32'h00000001) : axis_speed;
  assign reached    = (diff_mag <= `CVM_SPEED_TOL);
  assign standstill = (speed_mag <= `CVM_STILL_TOL);

  // Task is live in these states and may be cancelled there
  reg  [`CVM_ST_W-1:0] state;
  reg  [`CVM_ST_W-1:0] next_state;
  wire                 running;

  assign running = (state == `CVM_ST_RAMP) || (state == `CVM_ST_HOLD) ||
                   (state == `CVM_ST_STOP);

  // Start path decision, worked out combinationally from the inputs
  reg                    start_ok;
  reg [`CVM_CODE_W-1:0]  start_code;
  reg [`CVM_CODE_W-1:0]  start_detail;

  // Hold mode skips the parameter checks, since it ignores those inputs
  always @* begin
    start_ok     = 1'b1;
    start_code   = `CVM_FAULT_NONE;
    start_detail = `CVM_DETAIL_NONE;
    if (!axis_enabled) begin
      start_ok     = 1'b0;
      start_code   = `CVM_FAULT_DISABLED;
      start_detail = `CVM_DETAIL_AXIS;
    end else if (!hold_speed && chk_bad_dir) begin
      start_ok     = 1'b0;
      start_code   = `CVM_FAULT_DIR;
      start_detail = `CVM_DETAIL_PARAM;
    end else if (!hold_speed && chk_bad_speed) begin
      start_ok     = 1'b0;
      start_code   = `CVM_FAULT_SPEED;
      start_detail = `CVM_DETAIL_PARAM;
    end
  end

  // State transitions. A cancel by another task wins over a fresh
  // start edge in the same scan, so the superseded event is never lost.
  // Done, superseded and fault wait here until the request drops.
  always @* begin
    next_state = state;
    case (state)
      `CVM_ST_IDLE: begin
        next_state = `CVM_ST_IDLE;
      end
      `CVM_ST_RAMP: begin
        if (reached) begin
          next_state = `CVM_ST_HOLD;
        end
      end
      `CVM_ST_HOLD: begin
        next_state = `CVM_ST_HOLD;
      end
      `CVM_ST_STOP: begin
        if (standstill) begin
          next_state = `CVM_ST_DONE;
        end
      end
      `CVM_ST_DONE: begin
        if (!execute) begin
          next_state = `CVM_ST_IDLE;
        end
      end
      `CVM_ST_SUPER: begin
        if (!execute) begin
          next_state = `CVM_ST_IDLE;
        end
      end
      `CVM_ST_FAULT: begin
        if (!execute) begin
          next_state = `CVM_ST_IDLE;
        end
      end
      default: begin
        next_state = `CVM_ST_IDLE;
      end
    endcase
    if (start_rise) begin
      if (!start_ok) begin
        next_state = `CVM_ST_FAULT;
      end else if (hold_speed) begin
        next_state = `CVM_ST_HOLD;
      end else if (chk_zero) begin
        next_state = `CVM_ST_STOP;
      end else begin
        next_state = `CVM_ST_RAMP;
      end
    end
    if (other_task_start && (running || start_rise)) begin
      next_state = `CVM_ST_SUPER;
    end
  end

  // Registered state and every output of the unit
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state                <= `CVM_ST_IDLE;
      at_speed             <= 1'b0;
      busy                 <= 1'b0;
      superseded_flag      <= 1'b0;
      error                <= 1'b0;
      fault_code           <= `CVM_FAULT_NONE;
      fault_detail         <= `CVM_DETAIL_NONE;
      target_speed         <= `CVM_SPEED_ZERO;
      move_request         <= 1'b0;
      cancel_others        <= 1'b0;
      speed_mode_status    <= 1'b0;
      steady_motion_status <= 1'b0;
    end else begin
      state         <= next_state;
      move_request  <= 1'b0;
      cancel_others <= 1'b0;

      // Outputs follow the state being entered
      case (next_state)
        `CVM_ST_RAMP: begin
          busy            <= 1'b1;
          at_speed        <= 1'b0;
          superseded_flag <= 1'b0;
          error           <= 1'b0;
          fault_code      <= `CVM_FAULT_NONE;
          fault_detail    <= `CVM_DETAIL_NONE;
        end
        `CVM_ST_HOLD: begin
          busy            <= 1'b1;
          at_speed        <= 1'b1;
          superseded_flag <= 1'b0;
          error           <= 1'b0;
          fault_code      <= `CVM_FAULT_NONE;
          fault_detail    <= `CVM_DETAIL_NONE;
        end
        `CVM_ST_STOP: begin
          busy            <= 1'b1;
          at_speed        <= 1'b0;
          superseded_flag <= 1'b0;
          error           <= 1'b0;
          fault_code      <= `CVM_FAULT_NONE;
          fault_detail    <= `CVM_DETAIL_NONE;
        end
        `CVM_ST_DONE: begin
          // Busy drops in the same scan that at-speed rises
          busy     <= 1'b0;
          at_speed <= 1'b1;
        end
        `CVM_ST_SUPER: begin
          busy            <= 1'b0;
          at_speed        <= 1'b0;
          superseded_flag <= 1'b1;
        end
        `CVM_ST_FAULT: begin
          busy            <= 1'b0;
          at_speed        <= 1'b0;
          superseded_flag <= 1'b0;
          error           <= 1'b1;
          fault_code      <= start_rise ? start_code : fault_code;
          fault_detail    <= start_rise ? start_detail : fault_detail;
        end
        default: begin
          // Idle: flags released once the start request is low
          busy            <= 1'b0;
          at_speed        <= 1'b0;
          superseded_flag <= 1'b0;
          error           <= 1'b0;
          fault_code      <= `CVM_FAULT_NONE;
          fault_detail    <= `CVM_DETAIL_NONE;
        end
      endcase

      // Accepted start: load the target and take over the axis.
      // A restart while ramping loads the new target and pulses both requests again.
      if (start_rise && start_ok && !other_task_start) begin
        target_speed  <= hold_speed ? axis_speed
                                    : chk_target;
        move_request  <= 1'b1;
        cancel_others <= 1'b1;
        speed_mode_status    <= 1'b1;
        steady_motion_status <= 1'b0;
      end else if (other_task_start) begin
        // The new task's own unit sets the bits that suit it
        speed_mode_status    <= 1'b0;
        steady_motion_status <= 1'b0;
      end else if ((state == `CVM_ST_STOP) && standstill) begin
        steady_motion_status <= 1'b1;
      end
    end
  end

endmodule // cvm_move_velocity

`default_nettype wire

// ### bench/cvm_axis_model.sv
/* Drive and axis model for the constant-speed move unit.
   Assumes the unit's target_speed is held between tasks. */
`timescale 1ns/1ps
`default_nettype none

module cvm_axis_model #(
  parameter logic signed [31:0] STEP = 32'h00000004
) (
  input  wire logic               clk_sys,
  input  wire logic               resetn,
  input  wire logic               slow,
  input  wire logic signed [31:0] target_speed,
  output var  logic signed [31:0] axis_speed
);
  wire signed [31:0] diff = target_speed - axis_speed;
  wire signed [31:0] step = slow ? 32'sh00000001 : STEP;

  // Ramp one step a scan; slow mode stretches decel to test waits
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn)
      axis_speed <= 32'sh00000000;
    else if (diff > step)
      axis_speed <= axis_speed + step;
    else if (diff < -step)
      axis_speed <= axis_speed - step;
    else
      axis_speed <= target_speed;
  end
endmodule // cvm_axis_model

`default_nettype wire

// ### bench/cvm_move_velocity_props.sv
/* Port checker for cvm_move_velocity, bound below.
   Assumes one clock domain and resetn active low. */
`timescale 1ns/1ps
`default_nettype none
`include "cvm_defs.vh"

module cvm_mv_props (
  input wire logic               clk_sys,
  input wire logic               resetn,
  input wire logic               execute,
  input wire logic signed [31:0] speed_cmd,
  input wire logic        [15:0] direction,
  input wire logic               hold_speed,
  input wire logic signed [31:0] axis_speed,
  input wire logic               other_task_start,
  input wire logic               at_speed,
  input wire logic               busy,
  input wire logic               superseded_flag,
  input wire logic               error,
  input wire logic        [15:0] fault_code,
  input wire logic        [15:0] fault_detail,
  input wire logic signed [31:0] target_speed,
  input wire logic               move_request,
  input wire logic               cancel_others,
  input wire logic               speed_mode_status,
  input wire logic               steady_motion_status
);
  logic prev_exec;
  logic hold_task;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // Previous request level, so a fresh edge is not mistaken for a hold;
  // hold_task keeps whether the live task holds its present speed, as a
  // hold task started at standstill must not be taken for a zero task
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prev_exec <= 1'b0;
      hold_task <= 1'b0;
    end else begin
      prev_exec <= execute;
      if (execute && !prev_exec)
        hold_task <= hold_speed;
    end
  end

  // Expected target from speed and direction code
  function automatic logic signed [31:0] f_tgt(
      input logic signed [31:0] s, input logic [15:0] d);
    logic signed [31:0] m;
    m = (s < 0) ? -s : s;
    if (d == `CVM_DIR_POS)
      f_tgt = m;
    else if (d == `CVM_DIR_NEG)
      f_tgt = -m;
    else
      f_tgt = s;
  endfunction

  // Running task whose axis has matched its target, undisturbed
  sequence s_reach;
    busy && !other_task_start && axis_speed == target_speed
      && !(execute && !prev_exec);
  endsequence
  sequence s_started;
    move_request ##0 cancel_others && busy && speed_mode_status;
  endsequence

  a_move_on_edge: assert property (move_request |->
    $past(execute) && !$past(execute, 2))
    else $error("move issued without a start edge");
  a_start_pair: assert property (move_request |->
    s_started ##1 !move_request && !cancel_others)
    else $error("start pulses or status wrong");
  a_dir_decode: assert property (move_request &&
    !$past(hold_speed) |->
    target_speed == f_tgt($past(speed_cmd), $past(direction)))
    else $error("target does not follow direction code");
  a_hold_keep: assert property (move_request &&
    $past(hold_speed) |-> target_speed == $past(axis_speed) && at_speed)
    else $error("hold task did not keep present speed");
  a_reach_speed: assert property (s_reach ##0
    (target_speed != 0 || hold_task) |=> at_speed && busy)
    else $error("at-speed missing at target");
  a_zero_stop: assert property (s_reach ##0
    (target_speed == 0 && !hold_task)
    |=> at_speed && !busy && steady_motion_status)
    else $error("zero task did not finish at standstill");
  a_zero_one_scan: assert property (at_speed && !busy &&
    !execute && !other_task_start |=> !at_speed)
    else $error("zero task at-speed not released");
  a_latch_held: assert property (at_speed && !busy &&
    execute && prev_exec && !other_task_start |=> at_speed)
    else $error("held request did not latch at-speed");
  a_cancel_run: assert property (busy &&
    other_task_start |=> superseded_flag && !busy && !at_speed)
    else $error("cancel not reported");
  a_fault_words: assert property (
    (fault_code != 16'h0000) == error && (error || fault_detail == 16'h0000))
    else $error("fault words disagree with error");
  a_fault_no_move: assert property (error |->
    !move_request && !busy)
    else $error("faulted task moved the axis");
endmodule // cvm_mv_props

bind cvm_move_velocity cvm_mv_props u_props (
  .clk_sys(clk_sys), .resetn(resetn), .execute(execute),
  .speed_cmd(speed_cmd), .direction(direction), .hold_speed(hold_speed),
  .axis_speed(axis_speed), .other_task_start(other_task_start),
  .at_speed(at_speed), .busy(busy), .superseded_flag(superseded_flag),
  .error(error), .fault_code(fault_code), .fault_detail(fault_detail),
  .target_speed(target_speed), .move_request(move_request),
  .cancel_others(cancel_others), .speed_mode_status(speed_mode_status),
  .steady_motion_status(steady_motion_status)
);

`default_nettype wire

// ### bench/testbench.sv
/* Self-checking bench for the constant-speed move unit.
   Assumes the axis model ramps axis_speed toward target_speed. */
`timescale 1ns/1ps
`default_nettype none
`include "cvm_defs.vh"

module testbench;
  logic               clk_sys = 1'b0;
  logic               resetn = 1'b0;
  logic               execute = 1'b0;
  logic signed [31:0] speed_cmd = `CVM_SPEED_DEFAULT;
  logic        [15:0] direction = `CVM_DIR_SIGN;
  logic               hold_speed = 1'b0;
  logic               axis_enabled = 1'b1;
  logic               slow = 1'b0;
  logic               other_task_start = 1'b0;
  logic        [31:0] start_stop_speed = 32'h00000005;
  logic        [31:0] max_speed = 32'h00000064;
  wire signed  [31:0] axis_speed, target_speed;
  wire         [15:0] fault_code, fault_detail;
  wire                at_speed, busy, superseded_flag, error;
  wire                move_request, cancel_others;
  wire                speed_mode_status, steady_motion_status;
  int                 errors = 0;
  int                 comparisons = 0;
  int                 cycles = 0;
  logic        [31:0] tgt [3] = '{32'hFFFFFFCE, 32'h00000032, 32'hFFFFFFCE};
  logic        [15:0] f_dir [4] = '{16'h0003, 16'h0000, 16'h0000, 16'h0000};
  logic        [31:0] f_spd [4] = '{32'h1E, 32'hC8, 32'h02, 32'h1E};
  logic        [15:0] f_cod [4] = '{16'h0002, 16'h0003, 16'h0003, 16'h0001};
  logic        [15:0] f_det [4] = '{16'h0002, 16'h0002, 16'h0002, 16'h0001};

  always #20 clk_sys = ~clk_sys;

  cvm_move_velocity dut (
    .clk_sys(clk_sys), .resetn(resetn), .execute(execute),
    .speed_cmd(speed_cmd), .direction(direction), .hold_speed(hold_speed),
    .axis_enabled(axis_enabled), .axis_speed(axis_speed),
    .start_stop_speed(start_stop_speed), .max_speed(max_speed),
    .other_task_start(other_task_start), .at_speed(at_speed), .busy(busy),
    .superseded_flag(superseded_flag), .error(error),
    .fault_code(fault_code), .fault_detail(fault_detail),
    .target_speed(target_speed), .move_request(move_request),
    .cancel_others(cancel_others), .speed_mode_status(speed_mode_status),
    .steady_motion_status(steady_motion_status));

  cvm_axis_model axis (.clk_sys(clk_sys), .resetn(resetn), .slow(slow),
    .target_speed(target_speed), .axis_speed(axis_speed));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Inputs always move 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Raise the request; return just after the edge that answers it, while
  // the one-scan start pulses still stand
  task automatic start(input logic [31:0] s, input logic [15:0] d,
      input logic h);
    speed_cmd = s;
    direction = d;
    hold_speed = h;
    execute = 1'b1;
    tick(1);
  endtask

  // Two low scans between tasks keep every start a clean edge
  task automatic drop();
    execute = 1'b0;
    tick(2);
  endtask

  task automatic wait_at(input logic v);
    int n;
    n = 0;
    while (at_speed !== v && n < 400) begin
      tick(1);
      n++;
    end
    chk(at_speed, v);
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Hang guard: about 125 scans are needed, so 20000 is ample
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("[FAIL] %0t: run timed out", $time);
      conclude();
    end
  end

  initial begin
    tick(12);
    resetn = 1'b1;
    tick(4);
    chk(fault_code, 32'h0);
    // Every direction code; code 2 replaces code 1 in mid-ramp
    for (int i = 0; i < 3; i++) begin
      start(32'hFFFFFFCE, i[15:0], 1'b0);
      chk(move_request, 1'b1);
      chk(cancel_others, 1'b1);
      chk(target_speed, tgt[i]);
      chk(speed_mode_status, 1'b1);
      chk(superseded_flag, 1'b0);
      if (i != 1)
        wait_at(1'b1);
      drop();
    end
    tick(5);
    chk(busy, 1'b1);
    chk(at_speed, 1'b1);
    $display("test directions done");
    start(32'h000003E7, 16'h0007, 1'b1);
    chk(target_speed, 32'hFFFFFFCE);
    chk(at_speed, 1'b1);
    chk(error, 1'b0);
    drop();
    $display("test hold done");
    slow = 1'b1;
    start(32'h0, `CVM_DIR_SIGN, 1'b0);
    chk(busy, 1'b1);
    wait_at(1'b1);
    chk(busy, 1'b0);
    chk(steady_motion_status, 1'b1);
    tick(3);
    chk(at_speed, 1'b1);
    drop();
    chk(at_speed, 1'b0);
    slow = 1'b0;
    $display("test zero done");
    start(32'h0000001E, `CVM_DIR_POS, 1'b0);
    other_task_start = 1'b1;
    tick(1);
    other_task_start = 1'b0;
    chk(superseded_flag, 1'b1);
    chk(busy, 1'b0);
    chk(speed_mode_status, 1'b0);
    drop();
    chk(superseded_flag, 1'b0);
    $display("test cancel done");
    // Refusals; the last one on a disabled axis
    for (int i = 0; i < 4; i++) begin
      axis_enabled = (i != 3);
      start(f_spd[i], f_dir[i], 1'b0);
      chk(error, 1'b1);
      chk(fault_code, f_cod[i]);
      chk(fault_detail, f_det[i]);
      chk(move_request, 1'b0);
      drop();
      chk(fault_code, 32'h0);
    end
    axis_enabled = 1'b1;
    $display("test faults done");
    conclude();
  end
endmodule // testbench

`default_nettype wire
